/* core/triplet_search.v */
// triplet search command of the host-controlled single-wire master
// Behaviour
// - code 78h plus direction: read, read, write
// - both reads zero: write the direction bit
// - reads zero then one: write zero
// - reads one then zero: write one
// - both reads one: write one anyway
// - busy at code: no acknowledge, no activity
// - first slot starts within 262.5ns
// - command ends in three slots plus 262.5ns
// - read pointer left on status register
// - busy flag high for three slots
// - first read flag set at first sample
// - second flag and branch set at second sample
// - only direction bit 7 is used
// - acknowledge only valid codes and parameters
// - host reads return selected register repeatedly
`timescale 1ns/1ps
`include "triplet_defs.vh"
module triplet_search
(
  // clock and reset
  input  wire       CLK_SYS,
  input  wire       RESET_N,
  // received host bytes, decoded by the host-bus framing logic
  input  wire       BYTE_VALID,
  input  wire       BYTE_FIRST,
  input  wire [7:0] BYTE_DATA,
  input  wire       READ_REQ,
  // configuration
  input  wire       OVERDRIVE_SPEED_SELECT,
  input  wire       ACTIVE_PULLUP_SELECT,
  // host answers
  output reg        BYTE_ACK,
  output reg  [7:0] READ_DATA,
  output reg        READ_POINTER_STATUS,
  // status flags
  output reg        LINE_BUSY_FLAG,
  output reg        FIRST_READ_BIT_FLAG,
  output reg        SECOND_READ_BIT_FLAG,
  output reg        BRANCH_FLAG,
  // single-wire line
  input  wire       LINE_IN,
  output reg        LINE_OE,
  output reg        LINE_PULLUP_OE
);

  // ****************************************
  // input synchroniser and state
  // ****************************************
  localparam IDLE  = 2'd0;
  localparam PARAM = 2'd1;
  localparam RUN   = 2'd2;

  reg       line_meta;
  reg       line_sync;
  reg [1:0] state;
  reg [1:0] slot_idx;
  reg       dir_bit;
  reg       start;
  reg       wr_one;
  wire      eng_oe;
  wire      smp_pulse;
  wire      smp_bit;
  wire      eng_done;

  // branch choice for the third slot
  function choose;
    input first;
    input second;
    input dir;
    begin
      if (first == second)
        choose = first | dir;
      else
        choose = first;
    end
  endfunction

  // command code decode
  function is_triplet;
    input [7:0] code;
    begin
      is_triplet = (code == `CMD_TRIPLET);
    end
  endfunction

  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      line_meta <= 1'b1;
      line_sync <= 1'b1;
    end
    else
    begin
      line_meta <= LINE_IN;
      line_sync <= line_meta;
    end
  end

  slot_engine u_slot
  (
    .clk          (CLK_SYS),
    .reset_n      (RESET_N),
    .start        (start),
    .write_one    (wr_one),
    .overdrive    (OVERDRIVE_SPEED_SELECT),
    .line_in      (line_sync),
    .line_oe      (eng_oe),
    .sample_pulse (smp_pulse),
    .sample_bit   (smp_bit),
    .done         (eng_done)
  );

  // ****************************************
  // command sequencer
  // ****************************************
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      state                <= IDLE;
      slot_idx             <= 2'd0;
      dir_bit              <= 1'b0;
      start                <= 1'b0;
      wr_one               <= 1'b1;
      BYTE_ACK             <= 1'b0;
      READ_POINTER_STATUS  <= 1'b1;
      LINE_BUSY_FLAG       <= 1'b0;
      FIRST_READ_BIT_FLAG  <= 1'b0;
      SECOND_READ_BIT_FLAG <= 1'b0;
      BRANCH_FLAG          <= 1'b0;
    end
    else
    begin
      start    <= 1'b0;
      BYTE_ACK <= 1'b0;
      case (state)
        IDLE:
        begin
          if (BYTE_VALID && BYTE_FIRST && !LINE_BUSY_FLAG
              && is_triplet(BYTE_DATA))
          begin
            BYTE_ACK            <= 1'b1;
            READ_POINTER_STATUS <= 1'b1;
            state               <= PARAM;
          end
          else if (BYTE_VALID && BYTE_FIRST && LINE_BUSY_FLAG)
            state <= IDLE;
        end
        PARAM:
        begin
          if (BYTE_VALID && BYTE_FIRST)
          begin
            if (is_triplet(BYTE_DATA))
              BYTE_ACK <= 1'b1;
            else
              state <= IDLE;
          end
          else if (BYTE_VALID)
          begin
            dir_bit        <= BYTE_DATA[`DIR_BIT];
            BYTE_ACK       <= 1'b1;
            wr_one         <= 1'b1;
            start          <= 1'b1;
            slot_idx       <= 2'd0;
            LINE_BUSY_FLAG <= 1'b1;
            state          <= RUN;
          end
        end
        RUN:                             // bytes ignored while busy
        begin
          if (smp_pulse && slot_idx == 2'd0)
            FIRST_READ_BIT_FLAG <= smp_bit;
          if (smp_pulse && slot_idx == 2'd1)
          begin
            SECOND_READ_BIT_FLAG <= smp_bit;
            BRANCH_FLAG <= choose(FIRST_READ_BIT_FLAG, smp_bit, dir_bit);
          end
          if (eng_done)
          begin
            if (slot_idx == 2'd2)
            begin
              LINE_BUSY_FLAG <= 1'b0;
              state          <= IDLE;
            end
            else
            begin
              if (slot_idx == 2'd1)
                wr_one <= BRANCH_FLAG;
              slot_idx <= slot_idx + 2'd1;
              start    <= 1'b1;
            end
          end
        end
        default:
          state <= IDLE;
      endcase
    end
  end

  // ****************************************
  // line drive and host read data
  // ****************************************
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
    begin
      LINE_OE        <= 1'b0;
      LINE_PULLUP_OE <= 1'b0;
      READ_DATA      <= 8'h00;
    end
    else
    begin
      LINE_OE        <= eng_oe;
      LINE_PULLUP_OE <= ACTIVE_PULLUP_SELECT & LINE_BUSY_FLAG & ~eng_oe;
      if (READ_REQ)
        READ_DATA <= {BRANCH_FLAG, SECOND_READ_BIT_FLAG,
                      FIRST_READ_BIT_FLAG, 4'h0, LINE_BUSY_FLAG};
    end
  end

endmodule // triplet_search

/* include/triplet_defs.vh */
// constants for the single-wire triplet search block
`ifndef TRIPLET_DEFS_VH
`define TRIPLET_DEFS_VH
`define CMD_TRIPLET       8'h78
`define CMD_SET_PTR       8'hE1
`define PTR_STATUS        8'hF0
`define DIR_BIT           7
`define ST_BUSY           0
`define ST_FIRST          5
`define ST_SECOND         6
`define ST_BRANCH         7
`define SLOT_STD_NS       70
`define SLOT_OD_NS        60
`define SAMPLE_STD_NS     15
`define SAMPLE_OD_NS      12
`define LOW_STD_NS        6
`define LOW_OD_NS         1
`define CLK_PERIOD_NS     10
`define SLOT_STD_CYC      (`SLOT_STD_NS / `CLK_PERIOD_NS)
`define SLOT_OD_CYC       (`SLOT_OD_NS / `CLK_PERIOD_NS)
`define SAMPLE_STD_CYC    ((`SAMPLE_STD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define SYNC_LAG_CYC      3
`define SAMPLE_OD_CYC     ((`SAMPLE_OD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_STD_CYC       ((`LOW_STD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOW_OD_CYC        ((`LOW_OD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define W0_STD_CYC        (`SLOT_STD_CYC - 1)
`define W0_OD_CYC         (`SLOT_OD_CYC - 1)
`define START_MAX_NS      262.5
`endif

/* core/slot_engine.v */
// one single-wire time slot generator
`timescale 1ns/1ps
`include "triplet_defs.vh"
module slot_engine
(
  // clock and reset
  input  wire       clk,
  input  wire       reset_n,
  // control
  input  wire       start,
  input  wire       write_one,
  input  wire       overdrive,
  // line
  input  wire       line_in,
  output reg        line_oe,
  // result
  output reg        sample_pulse,
  output reg        sample_bit,
  output reg        done
);

  reg [7:0] count;
  reg       busy;
  reg       one;
  localparam [7:0] SLOT_STD = `SLOT_STD_CYC;
  localparam [7:0] SLOT_OD  = `SLOT_OD_CYC;
  localparam [7:0] LOW1_STD = `LOW_STD_CYC;
  localparam [7:0] LOW1_OD  = `LOW_OD_CYC;
  localparam [7:0] LOW0_STD = `W0_STD_CYC;
  localparam [7:0] LOW0_OD  = `W0_OD_CYC;
  // sample lags the output register and the two-flop line synchroniser
  localparam [7:0] SMP_STD  = `SAMPLE_STD_CYC + `SYNC_LAG_CYC;
  localparam [7:0] SMP_OD   = `SAMPLE_OD_CYC + `SYNC_LAG_CYC;
  wire [7:0] slot_len = overdrive ? SLOT_OD : SLOT_STD;
  wire [7:0] low_len  = one ? (overdrive ? LOW1_OD : LOW1_STD)
                            : (overdrive ? LOW0_OD : LOW0_STD);
  wire [7:0] smp_at   = overdrive ? SMP_OD : SMP_STD;

  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      count        <= 8'h00;
      busy         <= 1'b0;
      one          <= 1'b1;
      line_oe      <= 1'b0;
      sample_pulse <= 1'b0;
      sample_bit   <= 1'b0;
      done         <= 1'b0;
    end
    else
    begin
      sample_pulse <= 1'b0;
      done         <= 1'b0;
      if (start && !busy)
      begin
        busy    <= 1'b1;
        one     <= write_one;
        count   <= 8'h01;
        line_oe <= 1'b1;
      end
      else if (busy)
      begin
        count <= count + 8'h01;
        if (count == low_len)
          line_oe <= 1'b0;
        if (count == smp_at)
        begin
          sample_pulse <= 1'b1;
          sample_bit   <= line_in;
        end
        if (count == slot_len)
        begin
          busy <= 1'b0;
          done <= 1'b1;
        end
      end
    end
  end

endmodule // slot_engine

/* verif/slave_model.sv */
// single-wire slave answering the two read slots of a triplet
`timescale 1ns/1ps
module slave_model
(
  // clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // line and answer bits
  input  wire       line,
  input  wire [1:0] bits,
  output wire       pull
);
  // ****
  // answer a zero by stretching the low phase
  // ****
  reg [1:0] slot;
  reg [2:0] hold;
  reg       line_q;
  assign pull = hold != 3'h0;
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      slot   <= 2'h0;
      hold   <= 3'h0;
      line_q <= 1'b1;
    end
    else
    begin
      line_q <= line;
      if (line_q && !line)
      begin
        slot <= (slot == 2'h2) ? 2'h0 : slot + 2'h1;
        if (slot != 2'h2 && !bits[slot[0]])
          hold <= 3'h4;
      end
      else if (pull)
        hold <= hold - 3'h1;
    end
  end
endmodule // slave_model

/* verif/triplet_assertions.sv */
// assertions for the triplet search block
`timescale 1ns/1ps
module triplet_assertions
(
  // clock and reset
  input wire       CLK_SYS,
  input wire       RESET_N,
  // host side
  input wire       BYTE_VALID,
  input wire       BYTE_FIRST,
  input wire [7:0] BYTE_DATA,
  input wire       READ_REQ,
  input wire       BYTE_ACK,
  input wire [7:0] READ_DATA,
  // flags and line
  input wire       LINE_BUSY_FLAG,
  input wire       FIRST_READ_BIT_FLAG,
  input wire       SECOND_READ_BIT_FLAG,
  input wire       BRANCH_FLAG,
  input wire       LINE_OE,
  input wire       LINE_PULLUP_OE
);
  // ****
  // checks
  // ****
  default clocking @(posedge CLK_SYS); endclocking
  default disable iff (!RESET_N);
  wire       code = BYTE_VALID && BYTE_FIRST && BYTE_DATA == 8'h78;
  wire       busy = LINE_BUSY_FLAG;
  wire [7:0] stat = {BRANCH_FLAG, SECOND_READ_BIT_FLAG,
                     FIRST_READ_BIT_FLAG, 4'h0, LINE_BUSY_FLAG};
  reg  [7:0] busy_len;
  always @(posedge CLK_SYS or negedge RESET_N)
  begin
    if (!RESET_N)
      busy_len <= 8'h00;
    else
      busy_len <= busy ? busy_len + 8'h01 : 8'h00;
  end
  code_ack_a:
    assert property (code && !busy |=> BYTE_ACK) else $error("no ack");
  busy_nack_a:
    assert property (code && busy |=> !BYTE_ACK) else $error("ack busy");
  busy_start_a:
    assert property ($rose(busy) |-> $past(BYTE_VALID) && !$past(BYTE_FIRST))
    else $error("busy cause");
  slot_start_a:
    assert property ($rose(busy) |-> ##[0:3] LINE_OE) else $error("late");
  busy_span_a:
    assert property ($fell(busy) |-> busy_len >= 8'h12 && busy_len <= 8'h1C)
    else $error("busy span");
  first_update_a:
    assert property ($changed(FIRST_READ_BIT_FLAG) |-> busy_len >= 8'h02
      && busy_len <= 8'h08) else $error("first update");
  second_update_a:
    assert property ($changed(SECOND_READ_BIT_FLAG) || $changed(BRANCH_FLAG)
      |-> busy_len >= 8'h0A && busy_len <= 8'h10)
    else $error("second update");
  pullup_excl_a:
    assert property (!(LINE_PULLUP_OE && LINE_OE)) else $error("pullup fight");
  pullup_busy_a:
    assert property (LINE_PULLUP_OE |-> $past(busy)) else $error("pullup idle");
  branch_pick_a:
    assert property ($fell(busy) && (FIRST_READ_BIT_FLAG | SECOND_READ_BIT_FLAG)
      |-> BRANCH_FLAG == FIRST_READ_BIT_FLAG) else $error("branch");
  flags_hold_a:
    assert property (!busy |=> $stable(stat[7:5])) else $error("flags");
  read_data_a:
    assert property (READ_REQ |=> READ_DATA == $past(stat))
    else $error("read data");
endmodule // triplet_assertions
bind triplet_search triplet_assertions chk (.CLK_SYS(CLK_SYS),
  .RESET_N(RESET_N), .BYTE_VALID(BYTE_VALID), .BYTE_FIRST(BYTE_FIRST),
  .BYTE_DATA(BYTE_DATA), .READ_REQ(READ_REQ), .BYTE_ACK(BYTE_ACK),
  .READ_DATA(READ_DATA), .LINE_BUSY_FLAG(LINE_BUSY_FLAG),
  .FIRST_READ_BIT_FLAG(FIRST_READ_BIT_FLAG), .LINE_OE(LINE_OE),
  .SECOND_READ_BIT_FLAG(SECOND_READ_BIT_FLAG), .BRANCH_FLAG(BRANCH_FLAG),
  .LINE_PULLUP_OE(LINE_PULLUP_OE));

/* verif/testbench.sv */
// testbench for the triplet search block
`timescale 1ns/1ps
`include "triplet_defs.vh"
module testbench;
  // ****
  // bench
  // ****
  reg        clk, rst_n, bv, bf, rr, od, ap, oe_q;
  reg  [7:0] bd;
  reg  [1:0] ans;
  wire [7:0] rd;
  wire       ack, ptr, busy, f1, f2, br, oe, pu, pull;
  wire       line = ~(oe | pull);
  integer    miscompares, n_tests, run, slots, i, pu_n;
  triplet_search DUT (.CLK_SYS(clk), .RESET_N(rst_n), .BYTE_VALID(bv),
    .BYTE_FIRST(bf), .BYTE_DATA(bd), .READ_REQ(rr), .READ_DATA(rd),
    .OVERDRIVE_SPEED_SELECT(od), .ACTIVE_PULLUP_SELECT(ap), .BYTE_ACK(ack),
    .READ_POINTER_STATUS(ptr), .LINE_BUSY_FLAG(busy), .LINE_IN(line),
    .FIRST_READ_BIT_FLAG(f1), .SECOND_READ_BIT_FLAG(f2), .BRANCH_FLAG(br),
    .LINE_OE(oe), .LINE_PULLUP_OE(pu));
  slave_model sm (.clk(clk), .rst_n(rst_n), .line(line), .bits(ans),
    .pull(pull));
  initial
  begin
    clk = 0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    oe_q <= oe;
    if (oe)
      run <= oe_q ? run + 1 : 1;
    if (oe && !oe_q)
      slots <= slots + 1;
    if (pu)
      pu_n <= pu_n + 1;
  end
  task chk(input [7:0] got, input [7:0] exp);
  begin
    n_tests = n_tests + 1;
    if (got !== exp)
    begin
      miscompares = miscompares + 1;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  end
  endtask
  task send(input f, input [7:0] d, input a);
  begin
    @(posedge clk);
    bv <= 1;
    bf <= f;
    bd <= d;
    @(posedge clk);
    bv <= 0;
    #1 chk({7'h00, ack}, {7'h00, a});
  end
  endtask
  task wait_idle;
  begin
    i = 0;
    while (busy !== 1'b0 && i < 100)
    begin
      @(posedge clk);
      #1 i = i + 1;
    end
    chk({7'h00, busy}, 8'h00);
  end
  endtask
  task rd_status(input [7:0] e);
  begin
    @(posedge clk);
    rr <= 1;
    @(posedge clk);
    rr <= 0;
    #1 chk(rd, e);
  end
  endtask
  task trip(input [1:0] a, input [7:0] d);
    reg     e;
    integer w;
  begin
    e = (a[0] ^ a[1]) ? a[0] : (a[0] | d[7]);
    w = od ? `W0_OD_CYC : `W0_STD_CYC;
    ans <= a;
    slots = 0;
    send(1, `CMD_TRIPLET, 1);
    send(0, d, 1);
    wait_idle;
    chk(slots[7:0], 8'h03);
    chk(run[7:0], e ? 8'h01 : w[7:0]);
    rd_status({e, a[1], a[0], 5'h00});
  end
  endtask
  task print_verdict;
  begin
    if (miscompares == 0 && n_tests > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    {rst_n, bv, bf, rr, od, ap, oe_q} = 7'h00;
    {bd, ans} = 10'h003;
    {miscompares, n_tests, run, slots, pu_n} = 0;
    repeat (2) @(posedge clk);
    rst_n <= 1;
    trip(2'b00, 8'h80);
    trip(2'b00, 8'h7F);
    chk(pu_n[7:0], 8'h00);
    ap <= 1;
    trip(2'b10, 8'hFF);
    trip(2'b01, 8'h00);
    trip(2'b11, 8'h00);
    chk({7'h00, pu_n != 0}, 8'h01);
    @(posedge clk);
    od <= 1;
    trip(2'b00, 8'h80);
    trip(2'b10, 8'h00);
    slots = 0;
    send(1, `CMD_TRIPLET, 1);
    send(0, 8'h80, 1);
    send(1, `CMD_TRIPLET, 0);
    send(0, 8'h00, 0);
    chk({7'h00, ptr}, 8'h01);
    wait_idle;
    chk(slots[7:0], 8'h03);
    send(0, 8'h80, 0);
    print_verdict;
  end
  initial
  begin
    #50000 miscompares = miscompares + 1;
    print_verdict;
  end
endmodule // testbench
